// File: core/drc_ctrl.sv
// disturbance recorder control: state, triggers, capture addressing
// assumes sample strobes and extract/clear pulses come from same-clock logic;
// logic inputs and relay outputs arrive asynchronously from pins
//
// How it works
// - one of stopped, triggered, running; readable
// - trigger enters triggered until post interval ends
// - first record returns running; second stops
// - extracting a record while stopped resumes running
// - clear-all empties records and resumes running
// - writing triggered is manual trigger; others ignored
// - manual trigger rejected while trigger in progress
// - mode selects raw samples or magnitude/phase vectors
// - raw: twelve per cycle, 768 samples per record
// - vectors every 20ms, 384 per record
// - post-trigger length clamped 64 raw, 384 vector
// - seventeen-bit channel mask, over eight bits rejected
// - records carry all logic input and relay states
// - enabled logic inputs trigger when energised only
// - fifteen-bit relay mask triggers on operate only
// - relay mask bit n is output n+1
`timescale 1ns/1ps
`default_nettype none
`include "drc_defs.svh"
module drc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // settings side
  input wire logic mode_vec,
  input wire logic [9:0] post_len,
  input wire logic post_wr,
  input wire logic [`DRC_NCHAN-1:0] chan_mask_wr_data,
  input wire logic chan_mask_wr,
  input wire logic [`DRC_NLOGIC-1:0] logic_trig_mask,
  input wire logic [`DRC_NRELAY-1:0] relay_trig_mask,
  input wire logic state_wr,
  input wire drc_pkg::drc_state_type state_wr_data,
  input wire logic extract_done,
  input wire logic clear_all,
  // acquisition side
  input wire logic raw_strobe,
  input wire logic [15:0] raw_value,
  input wire logic [15:0] vec_value,
  input wire logic [`DRC_NLOGIC-1:0] logic_in_pin,
  input wire logic [`DRC_NRELAY-1:0] relay_out_pin,
  // status
  output drc_pkg::drc_state_type rec_state,
  output logic [1:0] rec_count,
  output logic [`DRC_NCHAN-1:0] chan_mask,
  output logic chan_mask_reject,
  output logic [9:0] post_len_eff,
  output logic manual_reject,
  // sample store write port
  output logic store_we,
  output drc_pkg::drc_wpos_type store_pos,
  output drc_pkg::drc_sample_type store_data,
  input wire logic store_ready
);
  import drc_pkg::*;
  // ==========================================================
  // pin synchronisers
  logic [`DRC_NLOGIC-1:0] li_s1_reg, li_s2_reg, li_s3_reg, li_q_reg;
  logic [`DRC_NRELAY-1:0] ro_s1_reg, ro_s2_reg, ro_s3_reg, ro_q_reg;
  logic [`DRC_NLOGIC-1:0] li_prev_reg;
  logic [`DRC_NRELAY-1:0] ro_prev_reg;
  genvar gi;
  generate
    for (gi = 0; gi < `DRC_NLOGIC; gi++) begin : g_li
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          li_s1_reg[gi] <= 1'b0;
          li_s2_reg[gi] <= 1'b0;
          li_s3_reg[gi] <= 1'b0;
          li_q_reg[gi] <= 1'b0;
        end else begin
          li_s1_reg[gi] <= logic_in_pin[gi];
          li_s2_reg[gi] <= li_s1_reg[gi];
          li_s3_reg[gi] <= li_s2_reg[gi];
          if (li_s2_reg[gi] == li_s3_reg[gi]) begin
            li_q_reg[gi] <= li_s3_reg[gi];
          end
        end
      end
    end
    // bit n of the relay vector is output n+1 throughout
    for (gi = 0; gi < `DRC_NRELAY; gi++) begin : g_ro
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          ro_s1_reg[gi] <= 1'b0;
          ro_s2_reg[gi] <= 1'b0;
          ro_s3_reg[gi] <= 1'b0;
          ro_q_reg[gi] <= 1'b0;
        end else begin
          ro_s1_reg[gi] <= relay_out_pin[gi];
          ro_s2_reg[gi] <= ro_s1_reg[gi];
          ro_s3_reg[gi] <= ro_s2_reg[gi];
          if (ro_s2_reg[gi] == ro_s3_reg[gi]) begin
            ro_q_reg[gi] <= ro_s3_reg[gi];
          end
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      li_prev_reg <= '0;
      ro_prev_reg <= '0;
    end else begin
      li_prev_reg <= li_q_reg;
      ro_prev_reg <= ro_q_reg;
    end
  end
  // ==========================================================
  // trigger detection
  logic li_rise, ro_rise, manual_req, trig_accept, cap_done;
  // only energise/operate edges count, never release
  assign li_rise = |(li_q_reg & ~li_prev_reg & logic_trig_mask);
  assign ro_rise = |(ro_q_reg & ~ro_prev_reg & relay_trig_mask);
  assign manual_req = state_wr && (state_wr_data == DRC_TRIGGERED);
  assign trig_accept = (rec_state == DRC_RUNNING) && (li_rise || ro_rise || manual_req);
  // ==========================================================
  // settings
  logic [4:0] ones;
  always_comb begin
    ones = '0;
    for (int i = 0; i < `DRC_NCHAN; i++) begin
      ones = ones + 5'(chan_mask_wr_data[i]);
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_mask <= `DRC_MASK_RESET;
      chan_mask_reject <= 1'b0;
    end else begin
      chan_mask_reject <= chan_mask_wr && (ones > `DRC_MAX_CHAN);
      if (chan_mask_wr && ones <= `DRC_MAX_CHAN) begin
        chan_mask <= chan_mask_wr_data;
      end
    end
  end
  // post length is latched and clamped to the mode's limit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      post_len_eff <= `DRC_POST_RESET;
    end else if (post_wr) begin
      if (!mode_vec && post_len > `DRC_RAW_POST_MAX) begin
        post_len_eff <= `DRC_RAW_POST_MAX;
      end else if (mode_vec && post_len > `DRC_VEC_POST_MAX) begin
        post_len_eff <= `DRC_VEC_POST_MAX;
      end else begin
        post_len_eff <= post_len;
      end
    end
  end
  // ==========================================================
  // sample timing
  localparam int VEC_TICKS = `DRC_VEC_TICKS;
  logic [21:0] vec_tick_reg;
  logic [3:0] cyc_phase_reg;
  logic vec_strobe, cyc_end, sample_stb;
  assign vec_strobe = (vec_tick_reg == 22'(VEC_TICKS - 1));
  // a raw cycle ends on the twelfth locked sample
  assign cyc_end = raw_strobe && (cyc_phase_reg == `DRC_RAW_PER_CYC - 4'h1);
  assign sample_stb = mode_vec ? vec_strobe : raw_strobe;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_tick_reg <= '0;
      cyc_phase_reg <= '0;
    end else begin
      vec_tick_reg <= vec_strobe ? '0 : vec_tick_reg + 22'h1;
      if (raw_strobe) begin
        cyc_phase_reg <= cyc_end ? '0 : cyc_phase_reg + 4'h1;
      end
    end
  end
  // ==========================================================
  // recorder state
  logic [9:0] post_cnt_reg, wr_addr_reg;
  logic slot_reg;
  logic post_tick, store_fire;
  // raw lengths count cycles, vector lengths count samples
  assign post_tick = mode_vec ? vec_strobe : cyc_end;
  assign cap_done = (rec_state == DRC_TRIGGERED) && (post_cnt_reg == 10'h000);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rec_state <= DRC_RUNNING;
      rec_count <= 2'h0;
      post_cnt_reg <= '0;
      slot_reg <= 1'b0;
      manual_reject <= 1'b0;
    end else begin
      // manual while triggered or stopped does not restart
      manual_reject <= manual_req && (rec_state != DRC_RUNNING);
      if (clear_all) begin
        rec_state <= DRC_RUNNING;
        rec_count <= 2'h0;
        slot_reg <= 1'b0;
      end else begin
        unique case (rec_state)
          DRC_RUNNING: begin
            if (trig_accept) begin
              rec_state <= DRC_TRIGGERED;
              post_cnt_reg <= post_len_eff;
            end
            if (extract_done && rec_count != 2'h0) begin
              rec_count <= rec_count - 2'h1;
            end
          end
          DRC_TRIGGERED: begin
            if (cap_done) begin
              slot_reg <= ~slot_reg;
              if (rec_count == 2'h0) begin
                rec_count <= 2'h1;
                rec_state <= DRC_RUNNING;
              end else begin
                rec_count <= 2'h2;
                rec_state <= DRC_STOPPED;
              end
            end else if (post_tick) begin
              post_cnt_reg <= post_cnt_reg - 10'h001;
            end
          end
          DRC_STOPPED: begin
            if (extract_done) begin
              rec_state <= DRC_RUNNING;
              rec_count <= 2'h1;
            end
          end
        endcase
      end
    end
  end
  // ==========================================================
  // circular capture into the current slot
  logic [9:0] depth;
  drc_sample_type samp;
  logic fifo_valid, fifo_ready;
  assign depth = mode_vec ? `DRC_VEC_DEPTH : `DRC_RAW_DEPTH;
  // all digital states travel with every sample
  assign samp = '{chan_mask: chan_mask, logic_in: li_q_reg, relay_out: ro_q_reg,
                  value: mode_vec ? vec_value : raw_value};
  assign store_fire = sample_stb && (rec_state != DRC_STOPPED) && fifo_ready;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_addr_reg <= '0;
    end else if (store_fire) begin
      wr_addr_reg <= (wr_addr_reg >= depth - 10'h1) ? '0 : wr_addr_reg + 10'h1;
    end
  end
  drc_fifo #(.WIDTH($bits(drc_sample_type) + 11), .DEPTH(`DRC_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_data({slot_reg, wr_addr_reg, samp}),
    .in_valid(store_fire),
    .in_ready(fifo_ready),
    .out_data({store_pos, store_data}),
    .out_valid(fifo_valid),
    .out_ready(store_ready)
  );
  assign store_we = fifo_valid;
  // ==========================================================
  // checks
  state_onehot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $onehot(rec_state)) else $error("state not one-hot");
  count_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rec_count == 2'h2) |-> (rec_state == DRC_STOPPED)) else $error("count 2 not stopped");
  count_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rec_count != 2'h3) else $error("count out of range");
  trig_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (trig_accept && !clear_all) |=> rec_state == DRC_TRIGGERED) else $error("trigger lost");
  stop_resume_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rec_state == DRC_STOPPED && extract_done) |=> rec_state == DRC_RUNNING)
    else $error("no resume");
  clear_all_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clear_all |=> (rec_count == 2'h0 && rec_state == DRC_RUNNING)) else $error("clear fail");
  // a rejected request may only let the countdown run on, never reload it
  manual_rej_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (manual_req && rec_state == DRC_TRIGGERED && !clear_all) |=>
    (manual_reject && (post_cnt_reg == $past(post_cnt_reg) ||
    post_cnt_reg == $past(post_cnt_reg) - 10'h001)))
    else $error("manual not rejected");
  mask_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_mask_wr && ones > `DRC_MAX_CHAN) |=> $stable(chan_mask)) else $error("mask taken");
  post_lim_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (post_wr && !mode_vec) |=> post_len_eff <= `DRC_RAW_POST_MAX) else $error("post over");
  cap_fill_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    rec_state == DRC_STOPPED);
  cap_first_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    rec_state == DRC_TRIGGERED ##1 rec_state == DRC_RUNNING);
  man_rej_c: cover property (@(posedge ref_clk) disable iff (!rst_n) manual_reject);
endmodule
`default_nettype wire

// File: core/drc_defs.svh
// constants for the disturbance recorder control block
// assumes inclusion by bare name from core/
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_NCHAN 17
`define DRC_NLOGIC 14
`define DRC_NRELAY 15
`define DRC_MAX_CHAN 5'h08
`define DRC_RAW_DEPTH 10'h300
`define DRC_VEC_DEPTH 10'h180
`define DRC_RAW_POST_MAX 10'h040
`define DRC_VEC_POST_MAX 10'h180
`define DRC_RAW_PER_CYC 4'hc
`define DRC_VEC_PERIOD_MS 20
`define DRC_CLK_MHZ 125
`define DRC_VEC_TICKS ((`DRC_VEC_PERIOD_MS * 1000 * `DRC_CLK_MHZ))
`define DRC_MASK_RESET 17'h00000
`define DRC_POST_RESET 10'h020
`define DRC_FIFO_DEPTH 4
`endif

// File: core/drc_fifo.sv
// small valid/ready FIFO for recorder samples
// assumes a single clock and asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module drc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, rd_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;
  // full only at DEPTH entries; the count is one bit wider than the pointers
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (int'(wr_reg) == DEPTH-1) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (int'(rd_reg) == DEPTH-1) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: core/drc_pkg.sv
// types for the disturbance recorder control block
// assumes drc_defs.svh is on the include path
`include "drc_defs.svh"
package drc_pkg;
  typedef enum logic [2:0] {
    DRC_RUNNING = 3'h1,
    DRC_TRIGGERED = 3'h2,
    DRC_STOPPED = 3'h4
  } drc_state_type;
  typedef struct packed {
    logic [`DRC_NCHAN-1:0] chan_mask;
    logic [`DRC_NLOGIC-1:0] logic_in;
    logic [`DRC_NRELAY-1:0] relay_out;
    logic [15:0] value;
  } drc_sample_type;
  typedef struct packed {
    logic slot;
    logic [9:0] addr;
  } drc_wpos_type;
endpackage

// File: dv/drc_ctrl_tb.sv
// self-checking bench for the recorder control block
// assumes drc_pkg compiled first and drc_defs.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "drc_defs.svh"
module drc_ctrl_tb;
  import drc_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mode_vec = 1'b0;
  logic [9:0] post_len = 10'h000;
  logic post_wr = 1'b0;
  logic [`DRC_NCHAN-1:0] chan_mask_wr_data = '0;
  logic chan_mask_wr = 1'b0;
  logic [`DRC_NLOGIC-1:0] logic_trig_mask = '0;
  logic [`DRC_NRELAY-1:0] relay_trig_mask = '0;
  logic state_wr = 1'b0;
  drc_state_type state_wr_data = DRC_RUNNING;
  logic extract_done = 1'b0;
  logic clear_all = 1'b0;
  logic raw_strobe = 1'b0;
  logic [15:0] raw_value = 16'h0000;
  logic [15:0] vec_value = 16'h1234;
  logic [`DRC_NLOGIC-1:0] logic_in_pin = '0;
  logic [`DRC_NRELAY-1:0] relay_out_pin = '0;
  logic store_ready = 1'b1;
  drc_state_type rec_state;
  logic [1:0] rec_count;
  logic [`DRC_NCHAN-1:0] chan_mask;
  logic chan_mask_reject;
  logic [9:0] post_len_eff;
  logic manual_reject;
  logic store_we;
  drc_wpos_type store_pos;
  drc_sample_type store_data;
  int fails = 0;
  int n_checks = 0;
  // clamp table: mode, requested, expected
  logic tm [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic [9:0] tv [4] = '{10'h064, 10'h040, 10'h1ff, 10'h17f};
  logic [9:0] te [4] = '{10'h040, 10'h040, 10'h180, 10'h17f};
  always #4 ref_clk = ~ref_clk;
  drc_ctrl drc_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .mode_vec(mode_vec), .post_len(post_len),
    .post_wr(post_wr), .chan_mask_wr_data(chan_mask_wr_data), .chan_mask_wr(chan_mask_wr),
    .logic_trig_mask(logic_trig_mask), .relay_trig_mask(relay_trig_mask),
    .state_wr(state_wr), .state_wr_data(state_wr_data), .extract_done(extract_done),
    .clear_all(clear_all), .raw_strobe(raw_strobe), .raw_value(raw_value),
    .vec_value(vec_value), .logic_in_pin(logic_in_pin), .relay_out_pin(relay_out_pin),
    .rec_state(rec_state), .rec_count(rec_count), .chan_mask(chan_mask),
    .chan_mask_reject(chan_mask_reject), .post_len_eff(post_len_eff),
    .manual_reject(manual_reject), .store_we(store_we), .store_pos(store_pos),
    .store_data(store_data), .store_ready(store_ready)
  );
  // ==========================================
  // checking and closing
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk_state(input drc_state_type exp);
    n_checks++;
    if (rec_state !== exp) begin
      fails++;
      $display("ERROR %0t state %h expected %h", $time, rec_state, exp);
    end
  endtask
  task automatic chk_bits(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // ==========================================
  // access tasks, all driven at the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic manual(input drc_state_type d);
    state_wr_data = d;
    state_wr = 1'b1;
    tick(1);
    state_wr = 1'b0;
  endtask
  task automatic wr_mask(input logic [`DRC_NCHAN-1:0] v);
    chan_mask_wr_data = v;
    chan_mask_wr = 1'b1;
    tick(1);
    chan_mask_wr = 1'b0;
  endtask
  task automatic wr_post(input logic [9:0] v);
    post_len = v;
    post_wr = 1'b1;
    tick(1);
    post_wr = 1'b0;
  endtask
  task automatic strobe(input int n);
    repeat (n) begin
      raw_strobe = 1'b1;
      tick(1);
      raw_strobe = 1'b0;
      tick(1);
    end
  endtask
  // bounded wait; pins pass a synchroniser so several cycles are allowed
  task automatic wait_state(input drc_state_type exp, input int lim);
    int i;
    for (i = 0; i < lim && rec_state !== exp; i++) tick(1);
    chk_state(exp);
    if (rec_state !== exp) report_and_stop();
  endtask
  // ==========================================
  // main sequence
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(1);
    chk_state(DRC_RUNNING);
    chk_bits(32'(rec_count), 32'h0, "count");
    chk_bits(32'(post_len_eff), 32'(`DRC_POST_RESET), "post");
    chk_bits(32'(store_we), 32'h0, "we");
    wr_mask(17'h1007f);
    chk_bits(32'(chan_mask_reject), 32'h0, "mask rej");
    chk_bits(32'(chan_mask), 32'h1007f, "mask");
    wr_mask(17'h1807f);
    chk_bits(32'(chan_mask_reject), 32'h1, "mask rej");
    chk_bits(32'(chan_mask), 32'h1007f, "mask kept");
    for (int k = 0; k < 4; k++) begin
      mode_vec = tm[k];
      wr_post(tv[k]);
      chk_bits(32'(post_len_eff), 32'(te[k]), "clamp");
    end
    mode_vec = 1'b0;
    // a stored entry carries mask, pins and value
    logic_in_pin = 14'h2a55;
    relay_out_pin = 15'h0003;
    raw_value = 16'hbeef;
    tick(6);
    raw_strobe = 1'b1;
    tick(1);
    raw_strobe = 1'b0;
    for (int i = 0; i < 6 && store_we !== 1'b1; i++) tick(1);
    chk_bits(32'(store_we), 32'h1, "we");
    chk_bits(32'(store_data.value), 32'hbeef, "value");
    chk_bits(32'(store_data.logic_in), 32'h2a55, "inputs");
    chk_bits(32'(store_data.relay_out), 32'h0003, "relays");
    chk_bits(32'(store_data.chan_mask), 32'h1007f, "entry mask");
    chk_bits(32'(store_pos), 32'h0, "entry pos");
    tick(1);
    strobe(11);
    // writes of running or stopped leave the state alone
    manual(DRC_STOPPED);
    chk_state(DRC_RUNNING);
    manual(DRC_RUNNING);
    chk_state(DRC_RUNNING);
    wr_post(10'h001);
    manual(DRC_TRIGGERED);
    chk_state(DRC_TRIGGERED);
    chk_bits(32'(manual_reject), 32'h0, "manual rej");
    manual(DRC_TRIGGERED);
    chk_bits(32'(manual_reject), 32'h1, "manual rej");
    strobe(11);
    chk_state(DRC_TRIGGERED);
    strobe(1);
    wait_state(DRC_RUNNING, 4);
    chk_bits(32'(rec_count), 32'h1, "count");
    // second record from a logic input fills the store
    wr_post(10'h000);
    logic_trig_mask = 14'h0008;
    logic_in_pin[3] = 1'b1;
    wait_state(DRC_TRIGGERED, 10);
    wait_state(DRC_STOPPED, 4);
    chk_bits(32'(rec_count), 32'h2, "count");
    extract_done = 1'b1;
    tick(1);
    extract_done = 1'b0;
    wait_state(DRC_RUNNING, 2);
    chk_bits(32'(rec_count), 32'h1, "count");
    // de-energising and unmasked relays must not trigger
    logic_in_pin[3] = 1'b0;
    relay_trig_mask = 15'h4000;
    relay_out_pin[13] = 1'b1;
    tick(10);
    chk_state(DRC_RUNNING);
    relay_out_pin[14] = 1'b1;
    wait_state(DRC_TRIGGERED, 10);
    wait_state(DRC_STOPPED, 4);
    chk_bits(32'(rec_count), 32'h2, "count");
    manual(DRC_TRIGGERED);
    chk_bits(32'(manual_reject), 32'h1, "manual rej");
    chk_state(DRC_STOPPED);
    clear_all = 1'b1;
    tick(1);
    clear_all = 1'b0;
    wait_state(DRC_RUNNING, 2);
    chk_bits(32'(rec_count), 32'h0, "count");
    tick(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
